/* adc_ctrl_top.sv */
// converter control: apb registers, trigger sensitivity, dedicated
// converter timing and result formatting, warm-up sequencing.
// assumes an apb master on core_clk_i and converter cores whose inputs
// are synchronous to core_clk_i; the shared converter supplies a tick.
//
// Implementation choices: the placing of the registers and register access over APB.
`timescale 1ns/100ps

// Behaviour
// - set bit level triggers, clear bit edge
// - sensitivity bits reset to zero
// - resolution code selects 12/10/8/6 bits
// - result left in 12 bits, low bits zeroed
// - save bit plus dma enable writes channel 0
// - save bit clear means no dma write
// - divisor field divides control clock
// - sample time counted in divided clocks
// - conversions wait for warm-up to elapse
// - one warm-up code, counted per converter
// - codes to four give 16, else 2^n
// - shared wake irq follows ready and enable
// - dedicated wake irq follows ready and enable
// - shared ready set after warm-up count
// - shared ready cleared when enable clears
// - alternate input result lands in primary register
// - result read uses current fractional format
// - unimplemented bits read zero, ignore writes
// - enable bit powers analog, starts warm-up
// - dedicated ready set after count, cleared
// - dma disabled holds dma logic reset
module adc_ctrl_top #(
  parameter int MAX_EXP = 15 // warm-up exponent clamp for simulation
) (
  input  wire logic        core_clk_i,       // control clock, 250 mhz
  input  wire logic        arst_n_i,         // async reset, active low
  input  wire logic        ce_i,             // clock enable
  input  wire logic        psel,             // apb select
  input  wire logic        penable,          // apb access phase
  input  wire logic        pwrite,           // apb direction
  input  wire logic [7:0]  paddr,            // apb byte address
  input  wire logic [31:0] pwdata,           // apb write data
  output logic      [31:0] prdata,           // apb read data
  output logic             pready,           // apb ready
  output logic             pslverr,          // apb error, unmapped
  input  wire logic [7:0]  trigger_i,        // per-input triggers
  output logic      [7:0]  trigger_fire_o,   // conversion requests
  input  wire logic        shared_tick_i,    // shared converter clock
  input  wire logic        alt_input_i,      // alternate input in use
  input  wire logic [11:0] conv_result_i,    // raw converter result
  input  wire logic        conv_valid_i,     // raw result valid
  output logic             conv_tick_o,      // divided conversion clock
  output logic             sampling_o,       // dedicated sampling
  output logic             conv_start_o,     // dedicated convert pulse
  output logic             ded_power_o,      // dedicated analog power
  output logic             shared_power_o,   // shared analog power
  output logic             ded_wake_irq_o,   // dedicated wake interrupt
  output logic             shared_wake_irq_o,// shared wake interrupt
  output logic             dma_reset_o,      // dma logic held in reset
  output logic             dma_write_o,      // dma write pulse
  output logic      [15:0] dma_data_o        // dma write data
);

  if (MAX_EXP < 4 || MAX_EXP > 15) begin : bad_exp
    $error("adc_ctrl_top: MAX_EXP must lie in 4..15");
  end

  // software-visible control state
  logic [7:0]  trigger_level_select_q;          // per-input sensitivity
  logic [1:0]  resolution_select_q;             // conversion width
  logic        channel0_dma_save_enable_q;      // channel 0 dma save
  logic [6:0]  conversion_clock_divisor_q;      // clock divisor
  logic [9:0]  sample_time_count_q;             // sample time in ticks
  logic [3:0]  warmup_count_code_q;             // shared warm-up code
  logic        shared_conv_wake_irq_enable_q;   // shared irq enable
  logic        dedicated_conv_wake_irq_enable_q;// dedicated irq enable
  logic        dma_interface_enable_q;          // global dma enable
  logic        fractional_format_select_q;      // fractional read format
  logic [11:0] conversion_result_word_q;        // channel 0 result

  // apb and datapath state
  logic [31:0] rdata_d;       // read mux
  logic        err_d;         // unmapped address
  logic        wr_en;         // write takes effect this edge
  logic        acc;           // access phase
  logic [7:0]  trig_prev_q;   // triggers last cycle
  logic [7:0]  fire_d;        // requests this cycle
  logic [6:0]  div_cnt_q;     // divider count
  logic        tick_d;        // divider reaches its end
  logic [9:0]  samp_cnt_q;    // sample ticks counted
  adc_ctrl_pkg::conv_state_type state_q; // sequencer state

  warmup_if ded_wu ();    // dedicated converter warm-up
  warmup_if shared_wu (); // shared converter warm-up

  // decode of the register map
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == adc_ctrl_pkg::trig_sens_off) ||
             (a == adc_ctrl_pkg::timing_off)    ||
             (a == adc_ctrl_pkg::warmup_off)    ||
             (a == adc_ctrl_pkg::dma_ctrl_off)  ||
             (a == adc_ctrl_pkg::result_off);
  endfunction : mapped

  assign acc   = psel && penable;
  assign wr_en = ce_i && acc && pready && pwrite && mapped(paddr);

  // read mux; fields not listed read as zero
  always_comb begin
    rdata_d = 32'h0000_0000;
    err_d   = !mapped(paddr);
    if (paddr == adc_ctrl_pkg::trig_sens_off) begin
      rdata_d[7:0] = trigger_level_select_q;
    end else if (paddr == adc_ctrl_pkg::timing_off) begin
      rdata_d[adc_ctrl_pkg::res_lsb +: 2] = resolution_select_q;
      rdata_d[adc_ctrl_pkg::save_bit]     = channel0_dma_save_enable_q;
      rdata_d[adc_ctrl_pkg::div_lsb +: 7] = conversion_clock_divisor_q;
      rdata_d[adc_ctrl_pkg::samc_lsb +: 10] = sample_time_count_q;
    end else if (paddr == adc_ctrl_pkg::warmup_off) begin
      rdata_d[adc_ctrl_pkg::code_lsb +: 4] = warmup_count_code_q;
      rdata_d[adc_ctrl_pkg::ien_shared_bit] = shared_conv_wake_irq_enable_q;
      rdata_d[adc_ctrl_pkg::ien_ded_bit] = dedicated_conv_wake_irq_enable_q;
      rdata_d[adc_ctrl_pkg::rdy_shared_bit] = shared_wu.ready;
      rdata_d[adc_ctrl_pkg::rdy_ded_bit]    = ded_wu.ready;
      rdata_d[adc_ctrl_pkg::en_shared_bit]  = shared_power_o;
      rdata_d[adc_ctrl_pkg::en_ded_bit]     = ded_power_o;
    end else if (paddr == adc_ctrl_pkg::dma_ctrl_off) begin
      rdata_d[adc_ctrl_pkg::dma_en_bit] = dma_interface_enable_q;
      rdata_d[adc_ctrl_pkg::fractional_format_select_bit]  = fractional_format_select_q;
    end else if (paddr == adc_ctrl_pkg::result_off) begin
      // format chosen at read time, so a format change shows at once
      if (fractional_format_select_q) begin
        rdata_d[adc_ctrl_pkg::fractional_format_select_lsb +: 12] =
          conversion_result_word_q;
      end else begin
        rdata_d[11:0] = conversion_result_word_q;
      end
    end
  end

  // apb answer: one wait state so that every output is a flop
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (ce_i) begin
      if (acc && !pready) begin
        pready  <= 1'b1;
        prdata  <= pwrite ? 32'h0000_0000 : rdata_d;
        pslverr <= err_d;
      end else begin
        pready  <= 1'b0;
        pslverr <= 1'b0;
      end
    end
  end

  // trigger sensitivity register
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      trigger_level_select_q <= adc_ctrl_pkg::trig_rst;
    end else if (wr_en && paddr == adc_ctrl_pkg::trig_sens_off) begin
      trigger_level_select_q <= pwdata[7:0];
    end
  end

  // dedicated converter timing register
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      resolution_select_q        <= adc_ctrl_pkg::res_rst;
      channel0_dma_save_enable_q <= 1'b0;
      conversion_clock_divisor_q <= adc_ctrl_pkg::div_rst;
      sample_time_count_q        <= adc_ctrl_pkg::samc_rst;
    end else if (wr_en && paddr == adc_ctrl_pkg::timing_off) begin
      resolution_select_q        <= pwdata[adc_ctrl_pkg::res_lsb +: 2];
      channel0_dma_save_enable_q <= pwdata[adc_ctrl_pkg::save_bit];
      conversion_clock_divisor_q <= pwdata[adc_ctrl_pkg::div_lsb +: 7];
      sample_time_count_q        <= pwdata[adc_ctrl_pkg::samc_lsb +: 10];
    end
  end

  // warm-up control; ready bits are not writable
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      warmup_count_code_q              <= adc_ctrl_pkg::code_rst;
      shared_conv_wake_irq_enable_q    <= 1'b0;
      dedicated_conv_wake_irq_enable_q <= 1'b0;
      shared_power_o                   <= 1'b0;
      ded_power_o                      <= 1'b0;
    end else if (wr_en && paddr == adc_ctrl_pkg::warmup_off) begin
      warmup_count_code_q <= pwdata[adc_ctrl_pkg::code_lsb +: 4];
      shared_conv_wake_irq_enable_q <=
        pwdata[adc_ctrl_pkg::ien_shared_bit];
      dedicated_conv_wake_irq_enable_q <=
        pwdata[adc_ctrl_pkg::ien_ded_bit];
      shared_power_o <= pwdata[adc_ctrl_pkg::en_shared_bit];
      ded_power_o    <= pwdata[adc_ctrl_pkg::en_ded_bit];
    end
  end

  // dma and format control
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dma_interface_enable_q     <= 1'b0;
      fractional_format_select_q <= 1'b0;
    end else if (wr_en && paddr == adc_ctrl_pkg::dma_ctrl_off) begin
      dma_interface_enable_q     <= pwdata[adc_ctrl_pkg::dma_en_bit];
      fractional_format_select_q <= pwdata[adc_ctrl_pkg::fractional_format_select_bit];
    end
  end

  // warm-up counters; the dedicated one runs on the divided clock
  assign ded_wu.enable    = ded_power_o;
  assign ded_wu.tick      = tick_d;
  assign ded_wu.code      = warmup_count_code_q;
  assign shared_wu.enable = shared_power_o;
  assign shared_wu.tick   = shared_tick_i;
  assign shared_wu.code   = warmup_count_code_q;

  warmup_counter #(.MAX_EXP(MAX_EXP)) ded_cnt (
    .core_clk_i (core_clk_i),
    .arst_n_i   (arst_n_i),
    .ce_i       (ce_i),
    .wu         (ded_wu)
  );

  warmup_counter #(.MAX_EXP(MAX_EXP)) shared_cnt (
    .core_clk_i (core_clk_i),
    .arst_n_i   (arst_n_i),
    .ce_i       (ce_i),
    .wu         (shared_wu)
  );

  // wake interrupts are levels of ready gated by their enables
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ded_wake_irq_o    <= 1'b0;
      shared_wake_irq_o <= 1'b0;
    end else if (ce_i) begin
      ded_wake_irq_o    <= ded_wu.ready &&
                           dedicated_conv_wake_irq_enable_q;
      shared_wake_irq_o <= shared_wu.ready &&
                           shared_conv_wake_irq_enable_q;
    end
  end

  // per-input request: level repeats while high, edge fires once
  always_comb begin
    fire_d = (trigger_i & trigger_level_select_q) |
             (trigger_i & ~trig_prev_q & ~trigger_level_select_q);
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      trig_prev_q    <= 8'h00;
      trigger_fire_o <= 8'h00;
    end else if (ce_i) begin
      trig_prev_q    <= trigger_i;
      trigger_fire_o <= fire_d;
    end
  end

  // divider: a divisor of zero or one gives one tick per cycle
  assign tick_d = ({1'b0, div_cnt_q} + 8'h01 >=
                   {1'b0, conversion_clock_divisor_q});

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      div_cnt_q   <= 7'h00;
      conv_tick_o <= 1'b0;
    end else if (ce_i) begin
      div_cnt_q   <= tick_d ? 7'h00 : div_cnt_q + 7'h01;
      conv_tick_o <= tick_d;
    end
  end

  // sequencer: wait for warm-up, sample, then convert
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q      <= adc_ctrl_pkg::conv_idle;
      samp_cnt_q   <= 10'h000;
      sampling_o   <= 1'b0;
      conv_start_o <= 1'b0;
    end else if (ce_i) begin
      conv_start_o <= 1'b0;
      case (state_q)
        adc_ctrl_pkg::conv_idle: begin
          samp_cnt_q <= 10'h000;
          // no conversion before the warm-up elapsed
          if (fire_d[0] && ded_power_o && ded_wu.ready) begin
            state_q    <= adc_ctrl_pkg::conv_sample;
            sampling_o <= 1'b1;
          end
        end
        adc_ctrl_pkg::conv_sample: begin
          if (tick_d) begin
            // zero sample time still samples for one tick
            if (samp_cnt_q + 10'h001 >= sample_time_count_q) begin
              state_q      <= adc_ctrl_pkg::conv_wait;
              sampling_o   <= 1'b0;
              conv_start_o <= 1'b1;
            end else begin
              samp_cnt_q <= samp_cnt_q + 10'h001;
            end
          end
        end
        adc_ctrl_pkg::conv_wait: begin
          // power loss abandons the conversion
          if (conv_valid_i || !ded_power_o) begin
            state_q <= adc_ctrl_pkg::conv_idle;
          end
        end
        default: begin
          state_q <= adc_ctrl_pkg::conv_idle;
        end
      endcase
    end
  end

  // result capture: alternate input results share the primary word
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      conversion_result_word_q <= 12'h000;
    end else if (ce_i && conv_valid_i &&
                 state_q == adc_ctrl_pkg::conv_wait) begin
      conversion_result_word_q <= conv_result_i &
        adc_ctrl_pkg::res_mask(resolution_select_q);
    end
  end

  // dma side: held in reset while disabled, saves only with save bit
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dma_reset_o <= 1'b1;
      dma_write_o <= 1'b0;
      dma_data_o  <= 16'h0000;
    end else if (ce_i) begin
      dma_reset_o <= !dma_interface_enable_q;
      dma_write_o <= 1'b0;
      if (dma_interface_enable_q && channel0_dma_save_enable_q &&
          conv_valid_i && state_q == adc_ctrl_pkg::conv_wait) begin
        dma_write_o <= 1'b1;
        dma_data_o  <= {4'h0, conv_result_i &
                        adc_ctrl_pkg::res_mask(resolution_select_q)};
      end else if (!dma_interface_enable_q) begin
        dma_data_o <= 16'h0000;
      end
    end
  end

endmodule : adc_ctrl_top

/* adc_ctrl_pkg.sv */
// package of register offsets, field positions, reset values and decodes
// for the converter control block; used by the top and the warm-up counter.
// assumes 32-bit apb data with one register per aligned word.
package adc_ctrl_pkg;

  // register byte offsets
  localparam logic [7:0] trig_sens_off   = 8'h00; // trigger sensitivity
  localparam logic [7:0] timing_off      = 8'h04; // dedicated timing
  localparam logic [7:0] warmup_off      = 8'h08; // analog warm-up control
  localparam logic [7:0] dma_ctrl_off    = 8'h0c; // dma and format control
  localparam logic [7:0] result_off      = 8'h10; // channel 0 result word

  // trigger sensitivity fields
  localparam int          trig_lvl_lsb   = 0;
  localparam int          trig_cnt       = 8;
  localparam logic [7:0]  trig_rst       = 8'h00;

  // timing fields
  localparam int          res_lsb        = 24;
  localparam int          save_bit       = 23;
  localparam int          div_lsb        = 16;
  localparam int          samc_lsb       = 0;
  localparam logic [1:0]  res_rst        = 2'h3;
  localparam logic [6:0]  div_rst        = 7'h00;
  localparam logic [9:0]  samc_rst       = 10'h000;

  // warm-up fields
  localparam int          code_lsb       = 24;
  localparam int          ien_shared_bit = 23;
  localparam int          ien_ded_bit    = 16;
  localparam int          rdy_shared_bit = 15;
  localparam int          rdy_ded_bit    = 8;
  localparam int          en_shared_bit  = 7;
  localparam int          en_ded_bit     = 0;
  localparam logic [3:0]  code_rst       = 4'h0;

  // dma and format control fields
  localparam int          dma_en_bit     = 31;
  localparam int          fractional_format_select_bit      = 0;

  // result layout, warm-up exponent floor and warm-up counter width
  localparam int          result_w       = 12;
  localparam int          fractional_format_select_lsb      = 20;
  localparam logic [3:0]  min_exp        = 4'h4;
  localparam int          warm_cnt_w     = 16;

  // conversion sequencer states
  typedef enum logic [1:0] {
    conv_idle,
    conv_sample,
    conv_wait
  } conv_state_type;

  // codes up to four all mean two to the fourth clocks
  function automatic logic [3:0] warmup_exponent(input logic [3:0] code);
    warmup_exponent = (code < min_exp) ? min_exp : code;
  endfunction : warmup_exponent

  // keep the top bits that the resolution covers, zero the rest
  function automatic logic [11:0] res_mask(input logic [1:0] sel);
    case (sel)
      2'h3:    res_mask = 12'hfff; // 12 bits
      2'h2:    res_mask = 12'hffc; // 10 bits
      2'h1:    res_mask = 12'hff0; // 8 bits
      default: res_mask = 12'hfc0; // 6 bits
    endcase
  endfunction : res_mask

endpackage : adc_ctrl_pkg

/* warmup_if.sv */
// carrier between the top and one warm-up counter.
// assumes both ends share core_clk_i; tick marks one converter clock.
`timescale 1ns/100ps
interface warmup_if;
  logic       enable; // analog enable bit
  logic       tick;   // one converter clock period elapsed
  logic [3:0] code;   // shared warm-up count code
  logic       ready;  // warm-up elapsed

  modport ctrl (output enable, output tick, output code, input ready);
  modport cnt  (input enable, input tick, input code, output ready);
endinterface : warmup_if

/* warmup_counter.sv */
// warm-up counter for one converter: counts its own clocks after enable.
// assumes tick is a one-cycle pulse in the core clock domain.
`timescale 1ns/100ps
module warmup_counter #(
  parameter int MAX_EXP = 15 // exponent clamp, shortens simulation
) (
  input  wire logic core_clk_i, // control clock
  input  wire logic arst_n_i,   // async reset, active low
  input  wire logic ce_i,       // clock enable, freezes all state
  warmup_if.cnt     wu          // enable, tick, code, ready
);

  if (MAX_EXP < 4 || MAX_EXP > 15) begin : bad_exp
    $error("warmup_counter: MAX_EXP must lie in 4..15");
  end

  logic [adc_ctrl_pkg::warm_cnt_w-1:0] cnt_q;    // clocks counted
  logic                                en_prev_q; // enable last cycle
  logic                                ready_q;   // warm-up done
  logic [3:0]                          exp_w;     // decoded exponent
  logic [adc_ctrl_pkg::warm_cnt_w:0]   target_w;  // clocks to count

  // decode the shared code; clamp only for shortened runs
  always_comb begin
    exp_w = adc_ctrl_pkg::warmup_exponent(wu.code);
    if (exp_w > 4'(MAX_EXP)) begin
      exp_w = 4'(MAX_EXP);
    end
    target_w = (adc_ctrl_pkg::warm_cnt_w+1)'(1) << exp_w;
  end

  // count in converter clocks; a rising enable restarts from zero
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_q     <= '0;
      en_prev_q <= 1'b0;
    end else if (ce_i) begin
      en_prev_q <= wu.enable;
      if (!wu.enable || !en_prev_q) begin
        cnt_q <= '0;
      end else if (wu.tick && !ready_q) begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  // ready once the count is reached, dropped as soon as enable clears
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ready_q <= 1'b0;
    end else if (ce_i) begin
      if (!wu.enable || !en_prev_q) begin
        ready_q <= 1'b0;
      end else if (wu.tick &&
                   {1'b0, cnt_q} + 1'b1 >= target_w) begin
        ready_q <= 1'b1;
      end
    end
  end

  assign wu.ready = ready_q;

endmodule : warmup_counter

/* adc_core_model.sv */
// converter core model: answers a convert pulse, makes the shared clock
// assumes start pulses are one cycle long and synchronous to core_clk_i
`timescale 1ns/100ps
module adc_core_model #(
  parameter logic [11:0] SAMPLE = 12'h9a5, // value the core converts
  parameter int          LAT    = 3        // cycles from start to result
) (
  input  wire logic        core_clk_i, // control clock
  input  wire logic        arst_n_i,   // async reset, active low
  input  wire logic        start_i,    // convert pulse
  output logic             valid_o,    // result valid pulse
  output logic      [11:0] result_o,   // converted value
  output logic             tick_o      // shared converter clock pulse
);
  int         cnt_q; // cycles left until the result
  logic [1:0] div_q; // shared clock divides the control clock by three

  // idle bus shows the inverse so a stale value never passes for a result
  assign result_o = valid_o ? SAMPLE : ~SAMPLE;

  // conversion latency
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_q   <= 0;
      valid_o <= 1'b0;
    end else begin
      valid_o <= (cnt_q == 1);
      if (start_i) cnt_q <= LAT;
      else if (cnt_q != 0) cnt_q <= cnt_q - 1;
    end
  end

  // shared converter clock, runs free
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      div_q  <= 2'h0;
      tick_o <= 1'b0;
    end else begin
      div_q  <= (div_q == 2'h2) ? 2'h0 : div_q + 2'h1;
      tick_o <= (div_q == 2'h2);
    end
  end
endmodule : adc_core_model

/* adc_ctrl_top_assertions.sv */
// port checker for the converter control top
// assumes ce_i stays high while it watches
`timescale 1ns/100ps
module adc_ctrl_top_assertions (
  input wire logic       core_clk_i,        // control clock
  input wire logic       arst_n_i,          // async reset, active low
  input wire logic       psel,              // apb select
  input wire logic       penable,           // apb access phase
  input wire logic       pready,            // apb ready
  input wire logic [7:0] trigger_i,         // triggers
  input wire logic [7:0] trigger_fire_o,    // conversion requests
  input wire logic       sampling_o,        // dedicated sampling
  input wire logic       conv_start_o,      // convert pulse
  input wire logic       ded_power_o,       // dedicated power
  input wire logic       shared_power_o,    // shared power
  input wire logic       ded_wake_irq_o,    // dedicated wake irq
  input wire logic       shared_wake_irq_o, // shared wake irq
  input wire logic       dma_reset_o,       // dma held in reset
  input wire logic       dma_write_o        // dma write pulse
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);
  sequence s_one_wait; !pready ##1 pready; endsequence
  sequence s_sample_end; $fell(sampling_o); endsequence
  property p_apb_wait; $rose(psel && penable) |-> s_one_wait; endproperty
  a_apb_wait: assert property (p_apb_wait) else $error("apb answer off");
  property p_fire_rise; $rose(trigger_i[0]) |=> trigger_fire_o[0]; endproperty
  a_fire_rise: assert property (p_fire_rise) else $error("edge lost");
  property p_fire_cause; (trigger_fire_o & ~$past(trigger_i)) == 8'h00;
  endproperty
  a_fire_cause: assert property (p_fire_cause) else $error("stray fire");
  property p_ded_warm; $rose(ded_power_o) |-> !ded_wake_irq_o [*8]; endproperty
  a_ded_warm: assert property (p_ded_warm) else $error("early ready");
  property p_sh_warm; $rose(shared_power_o) |-> !shared_wake_irq_o [*8];
  endproperty
  a_sh_warm: assert property (p_sh_warm) else $error("early ready");
  property p_start; s_sample_end |-> ##[0:1] conv_start_o; endproperty
  a_start: assert property (p_start) else $error("no convert");
  property p_powered; $rose(sampling_o) |-> ded_power_o; endproperty
  a_powered: assert property (p_powered) else $error("cold sample");
  property p_dma_off; dma_write_o |-> !dma_reset_o; endproperty
  a_dma_off: assert property (p_dma_off) else $error("dma in reset");
endmodule : adc_ctrl_top_assertions

bind adc_ctrl_top adc_ctrl_top_assertions u_chk (.core_clk_i, .arst_n_i,
  .psel, .penable, .pready, .trigger_i, .trigger_fire_o, .sampling_o,
  .conv_start_o, .ded_power_o, .shared_power_o, .ded_wake_irq_o,
  .shared_wake_irq_o, .dma_reset_o, .dma_write_o);

/* tb.sv */
// testbench for the converter control top, register tasks over apb
// assumes the core model on the converter side
`timescale 1ns/100ps
module tb;
  localparam logic [11:0] sample = 12'h9a5; // value the core returns
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, alt, err;
  logic tick, cval, ctick, samp, cst, dpow, spow, dirq, sirq, drst, dwr;
  logic [7:0]  paddr, trig, fire;
  logic [11:0] cres, msk;
  logic [15:0] ddata;
  logic [31:0] pwdata, prdata, rd;
  int          fail_count, n_compared, t, td, ts, n;

  adc_ctrl_top #(.MAX_EXP(5)) uut (.core_clk_i(clk), .arst_n_i(rst_n),
    .ce_i(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .trigger_i(trig), .trigger_fire_o(fire),
    .shared_tick_i(tick), .alt_input_i(alt), .conv_result_i(cres),
    .conv_valid_i(cval), .conv_tick_o(ctick), .sampling_o(samp),
    .conv_start_o(cst), .ded_power_o(dpow), .shared_power_o(spow),
    .ded_wake_irq_o(dirq), .shared_wake_irq_o(sirq), .dma_reset_o(drst),
    .dma_write_o(dwr), .dma_data_o(ddata));
  adc_core_model #(.SAMPLE(sample)) u_core (.core_clk_i(clk),
    .arst_n_i(rst_n), .start_i(cst), .valid_o(cval), .result_o(cres),
    .tick_o(tick));

  // 250 mhz control clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: saw %h, want %h", $time, seen, exp);
    end
  endtask : check

  // one apb transfer; holds the request until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) fail_count++;
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic chk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(rd, e);
  endtask : chk

  task automatic give_verdict;
    $display("compared %0d, wrong %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict

  // watchdog, far above the several hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    give_verdict;
  end

  initial begin
    {rst_n, psel, penable, pwrite, alt, paddr, trig, pwdata} = '0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    chk(8'h00, 32'h0);
    chk(8'h04, 32'h03000000);
    check(drst, 1'b1);
    wr(8'h00, '1);
    chk(8'h00, 32'hff);
    wr(8'h04, '1);
    chk(8'h04, 32'h03ff03ff);
    wr(8'h08, '1);
    chk(8'h08, 32'h0f810081);
    check({spow, dpow}, 2'h3);
    apb(1'b0, 8'h20, 32'h0);
    check({err, rd[30:0]}, 32'h80000000);
    wr(8'h00, 32'h2);
    trig <= 8'h03;
    repeat (3) @(posedge clk);
    check(fire, 8'h02);
    check(samp, 1'b0);
    trig <= 8'h00;
    wr(8'h04, 32'h03020003);
    for (int i = 0; i < 2; i++) begin
      wr(8'h08, 32'h0);
      wr(8'h08, 32'h00810081 | (i * 5) << 24);
      {t, td, ts} = '0;
      while ((td == 0 || ts == 0) && t < 300) begin
        @(posedge clk);
        t++;
        if (dirq === 1'b1 && td == 0) td = t;
        if (sirq === 1'b1 && ts == 0) ts = t;
      end
      check(td >= 32 * (i + 1) - 2 && td <= 32 * (i + 1) + 8, 1'b1);
      check(ts >= 48 * (i + 1) - 3 && ts <= 48 * (i + 1) + 8, 1'b1);
    end
    chk(8'h08, 32'h05818181);
    for (int i = 0; i < 6; i++) begin
      msk = 12'hfff << (2 * (3 - i % 4));
      wr(8'h04, {6'h0, 2'(i % 4), i != 4, 7'h02, 6'h0, 10'h003});
      wr(8'h0c, {i != 5, 31'h0});
      alt  <= (i == 3);
      trig <= 8'h01;
      @(posedge clk);
      trig <= 8'h00;
      {n, t} = '0;
      repeat (40) begin
        @(posedge clk);
        if (dwr === 1'b1) n++;
        t += ctick;
        if (dwr === 1'b1) check(ddata, {4'h0, sample & msk});
      end
      check(n, i < 4);
      check(t, 20);
      chk(8'h10, sample & msk);
      wr(8'h0c, 32'h1);
      chk(8'h10, {sample & msk, 20'h0});
    end
    wr(8'h08, 32'h05810000);
    chk(8'h08, 32'h05810000);
    check({sirq, dirq, spow, dpow}, 4'h0);
    give_verdict;
  end
endmodule : tb
